// ==== vg_cfg.svh ====
// Field positions, reset values and count constants of the video generator.
`ifndef VG_CFG_SVH
`define VG_CFG_SVH
`define VG_MODE_RANGE 30:29
`define VG_DEPTH_BIT 28
`define VG_BCAST_CHROMA_BIT 27
`define VG_BASE_CHROMA_BIT 26
`define VG_AUDIO_RANGE 25:23
`define VG_GROUP_RANGE 11:9
`define VG_MASK_RANGE 7:0
`define VG_PIXEL_RANGE 19:12
`define VG_FRAME_RANGE 11:0
`define VG_CFG_RESET 32'h0000_0000
`define VG_SCL_RESET 32'h0000_0000
`define VG_PIXEL_ZERO 8'h00
`define VG_PIXEL_ONE 8'h01
`define VG_FRAME_ZERO 12'h000
`define VG_FRAME_ONE 12'h001
`define VG_GROUP_COUNT 4
`define VG_GROUP_LAST 3'h3
`define VG_GROUP_ZERO 3'h0
`define VG_LANE_OFF 8'h00
`define VG_LANE_UNDRIVEN_N 8'hff
`define VG_PINS_OFF 32'h0000_0000
`define VG_PINS_UNDRIVEN_N 32'hffff_ffff
`define VG_MASK_ALL 8'hff
`define VG_LUMA_RANGE 2:0
`define VG_HUE_BIT 3
`define VG_PALETTE_RESET 32'h0000_0000
`endif

// ==== vg_pkg.sv ====
// Types shared by the video generator files.
package vg_pkg;
   typedef enum logic [1:0] {
      VG_OFF = 2'h0,
      VG_VGA = 2'h1,
      VG_COMP_BCAST_HIGH = 2'h2,
      VG_COMP_BASE_HIGH = 2'h3
   } vg_mode_t;
endpackage

// ==== vg_pixel_shifter.sv ====
// Pixel long shift register and palette lookup of the video generator.
`timescale 1ns/1ps
`include "vg_cfg.svh"
module vg_pixel_shifter (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Control
   input wire logic load,
   input wire logic load_valid,
   input wire logic shift,
   input wire logic colour_depth_select,
   // New frame data
   input wire logic [31:0] new_pixels,
   input wire logic [31:0] new_palette,
   // Current pixel
   output logic [1:0] pix_index,
   output logic [7:0] colour
);
   logic [31:0] sh_q;
   logic [31:0] sh_d;
   logic [31:0] held_q;
   logic [31:0] pal_q;
   wire [31:0] load_src = load_valid ? new_pixels : held_q;
   wire [31:0] sh_one = {1'b0, sh_q[31:1]};
   wire [31:0] sh_two = {2'b00, sh_q[31:2]};

   // A missed hand-over repeats the previous long rather than blanking.
   assign sh_d = load ? load_src : shift ? (colour_depth_select ? sh_two : sh_one) : sh_q;

   // RULE_05 - one-bit pixels
   // RULE_06 - two-bit pixels
   assign pix_index = colour_depth_select ? sh_q[1:0] : {1'b0, sh_q[0]};
   assign colour = pal_q[{pix_index, 3'b000} +: 8];

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sh_q <= `VG_PALETTE_RESET;
         held_q <= `VG_PALETTE_RESET;
         pal_q <= `VG_PALETTE_RESET;
      end
      else
      begin
         sh_q <= sh_d;
         if (load && load_valid)
         begin
            held_q <= new_pixels;
            pal_q <= new_palette;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   two_colour_idx_a: assert property (!colour_depth_select |-> pix_index[1] == 1'b0) // RULE_05
      else $error("two-colour mode selected palette entry above one");
   four_colour_step_a: assert property ( // RULE_06
      shift && !load && colour_depth_select |=> sh_q[1:0] == $past(sh_q[3:2]))
      else $error("four-colour shift did not advance two bits");
endmodule

// ==== vg_core.sv ====
// Per-core video generator: configuration and scale registers, timing and pin output.
`timescale 1ns/1ps
`include "vg_cfg.svh"
// Function
// RULE_01 - Output mode zero produces no video at all.
// RULE_02 - Mode one is VGA, eight-bit parallel on all eight group pins.
// RULE_03 - Mode two puts broadcast on upper four pins, baseband on lower four.
// RULE_04 - Mode three puts baseband on upper four pins, broadcast on lower four.
// RULE_05 - Colour-depth bit clear: 32 one-bit pixels, palette colours zero and one.
// RULE_06 - Colour-depth bit set: 16 two-bit pixels, palette colours zero to three.
// RULE_07 - Bit 27 enables chroma on the broadcast signal.
// RULE_08 - Bit 26 enables chroma on the baseband signal.
// RULE_09 - Three-bit field n picks core n's counter A clock as audio sub-carrier.
// RULE_10 - Pin-group field n selects pins 8n to 8n+7; four to seven reserved.
// RULE_11 - Eight-bit mask chooses which pins of the group carry video.
// RULE_12 - Pixel period sets synthesiser clocks before each next pixel.
// RULE_13 - Frame period sets synthesiser clocks before each next frame.
// RULE_14 - Period counters count counter A synthesiser clocks only.
// RULE_15 - Each frame is one 32-bit pixel long taken through the handshake.
// RULE_16 - Reading either register returns its current contents.
// RULE_17 - Unused bits of both registers do not affect behaviour.
module vg_core (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register access from the owning core
   input wire logic cfg_wr,
   input wire logic scl_wr,
   input wire logic [31:0] wr_data,
   output logic [31:0] video_configuration_q,
   output logic [31:0] video_scale_q,
   // Synthesiser clocks
   input wire logic counter_a_synth_clock,
   input wire logic [7:0] core_synth_level,
   output logic audio_subcarrier_q,
   // Pixel long handshake
   input wire logic pixel_long_valid,
   input wire logic [31:0] pixel_long_data,
   input wire logic [31:0] palette_data,
   output logic pixel_long_ready_q,
   // Video pins
   output logic [31:0] video_out_q,
   output logic [31:0] video_drive_n_q
);
   // RULE_17 - only defined fields used
   wire [1:0] mode_bits = video_configuration_q[`VG_MODE_RANGE];
   wire colour_depth_select = video_configuration_q[`VG_DEPTH_BIT];
   wire broadcast_colour_enable = video_configuration_q[`VG_BCAST_CHROMA_BIT];
   wire baseband_colour_enable = video_configuration_q[`VG_BASE_CHROMA_BIT];
   wire [2:0] audio_subcarrier_source = video_configuration_q[`VG_AUDIO_RANGE];
   wire [2:0] output_pin_group = video_configuration_q[`VG_GROUP_RANGE];
   wire [7:0] output_pin_mask = video_configuration_q[`VG_MASK_RANGE];
   wire [7:0] pixel_period = video_scale_q[`VG_PIXEL_RANGE];
   wire [11:0] frame_period = video_scale_q[`VG_FRAME_RANGE];
   vg_pkg::vg_mode_t output_kind_select;
   assign output_kind_select = vg_pkg::vg_mode_t'(mode_bits);

   logic [7:0] px_cnt_q;
   logic [7:0] px_cnt_d;
   logic [11:0] fr_cnt_q;
   logic [11:0] fr_cnt_d;
   logic [31:0] pin_d;
   logic [31:0] drv_n_d;
   wire tick = counter_a_synth_clock;

   // RULE_14 - counts advance on synth ticks
   // RULE_13 - frame boundary
   wire frame_due = tick && (fr_cnt_q == `VG_FRAME_ZERO);
   // RULE_12 - pixel boundary
   wire pixel_shift = tick && !frame_due && (px_cnt_q == `VG_PIXEL_ZERO);

   // A period of zero wraps the counter, so it lasts the full counter range.
   assign px_cnt_d = (frame_due || pixel_shift) ? pixel_period - `VG_PIXEL_ONE :
                     tick ? px_cnt_q - `VG_PIXEL_ONE : px_cnt_q;
   assign fr_cnt_d = frame_due ? frame_period - `VG_FRAME_ONE :
                     tick ? fr_cnt_q - `VG_FRAME_ONE : fr_cnt_q;

   logic [1:0] pix_index;
   logic [7:0] colour;

   // RULE_15 - new long taken at each frame
   vg_pixel_shifter u_shifter (
      .clk(clk),
      .sys_rst(sys_rst),
      .load(frame_due),
      .load_valid(pixel_long_valid),
      .shift(pixel_shift),
      .colour_depth_select(colour_depth_select),
      .new_pixels(pixel_long_data),
      .new_palette(palette_data),
      .pix_index(pix_index),
      .colour(colour)
   );

   // RULE_07 - broadcast chroma gate
   wire [3:0] bcast_nib = {colour[`VG_HUE_BIT] & broadcast_colour_enable, colour[`VG_LUMA_RANGE]};
   // RULE_08 - baseband chroma gate
   wire [3:0] base_nib = {colour[`VG_HUE_BIT] & baseband_colour_enable, colour[`VG_LUMA_RANGE]};

   // RULE_02 - VGA byte
   // RULE_03 - broadcast high
   // RULE_04 - baseband high
   wire [7:0] group_val = (output_kind_select == vg_pkg::VG_VGA) ? colour :
                          (output_kind_select == vg_pkg::VG_COMP_BCAST_HIGH) ?
                          {bcast_nib, base_nib} :
                          (output_kind_select == vg_pkg::VG_COMP_BASE_HIGH) ?
                          {base_nib, bcast_nib} : `VG_LANE_OFF;

   // RULE_01 - mode off blanks
   // RULE_10 - reserved groups blank
   wire video_on = (output_kind_select != vg_pkg::VG_OFF) &&
                   (output_pin_group <= `VG_GROUP_LAST);

   // RULE_10 - group lane select
   // RULE_11 - pin mask applied
   genvar g;
   generate
      for (g = 0; g < `VG_GROUP_COUNT; g = g + 1)
      begin : g_lane
         wire lane_sel = video_on && (output_pin_group == 3'(g));
         assign pin_d[g*8 +: 8] = lane_sel ? (group_val & output_pin_mask) : `VG_LANE_OFF;
         assign drv_n_d[g*8 +: 8] = lane_sel ? ~output_pin_mask : `VG_LANE_UNDRIVEN_N;
      end
   endgenerate

   // RULE_09 - sub-carrier source select
   wire aud_pick = core_synth_level[audio_subcarrier_source];

   // RULE_16 - registers read back whole
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         video_configuration_q <= `VG_CFG_RESET;
         video_scale_q <= `VG_SCL_RESET;
      end
      else
      begin
         if (cfg_wr)
            video_configuration_q <= wr_data;
         if (scl_wr)
            video_scale_q <= wr_data;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         px_cnt_q <= `VG_PIXEL_ZERO;
         fr_cnt_q <= `VG_FRAME_ZERO;
         pixel_long_ready_q <= 1'b0;
         audio_subcarrier_q <= 1'b0;
         video_out_q <= `VG_PINS_OFF;
         video_drive_n_q <= `VG_PINS_UNDRIVEN_N;
      end
      else
      begin
         px_cnt_q <= px_cnt_d;
         fr_cnt_q <= fr_cnt_d;
         pixel_long_ready_q <= frame_due && pixel_long_valid;
         audio_subcarrier_q <= aud_pick;
         video_out_q <= pin_d;
         video_drive_n_q <= drv_n_d;
      end
   end

   // Helper counters of ticks since the last pixel and frame boundary.
   logic [7:0] px_seen_q;
   logic [11:0] fr_seen_q;
   logic px_clean_q;
   logic fr_clean_q;
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         px_seen_q <= `VG_PIXEL_ZERO;
         fr_seen_q <= `VG_FRAME_ZERO;
         px_clean_q <= 1'b0;
         fr_clean_q <= 1'b0;
      end
      else
      begin
         px_seen_q <= (frame_due || pixel_shift) ? `VG_PIXEL_ZERO :
                      tick ? px_seen_q + `VG_PIXEL_ONE : px_seen_q;
         fr_seen_q <= frame_due ? `VG_FRAME_ZERO : tick ? fr_seen_q + `VG_FRAME_ONE : fr_seen_q;
         px_clean_q <= !scl_wr && (px_clean_q || frame_due || pixel_shift);
         fr_clean_q <= !scl_wr && (fr_clean_q || frame_due);
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_group0_all;
      output_pin_group == `VG_GROUP_ZERO && output_pin_mask == `VG_MASK_ALL;
   endsequence

   sequence s_long_offer;
      frame_due && pixel_long_valid;
   endsequence

   sequence s_ready_once;
      pixel_long_ready_q ##1 (!pixel_long_ready_q || $past(frame_due && pixel_long_valid));
   endsequence

   mode_off_blank_a: assert property ( // RULE_01
      output_kind_select == vg_pkg::VG_OFF |=>
      video_drive_n_q == `VG_PINS_UNDRIVEN_N && video_out_q == `VG_PINS_OFF)
      else $error("video pins driven while output mode is off");
   vga_byte_out_a: assert property ( // RULE_02
      output_kind_select == vg_pkg::VG_VGA ##0 s_group0_all |=>
      video_drive_n_q[7:0] == `VG_LANE_OFF && video_out_q[7:0] == $past(colour))
      else $error("VGA mode did not drive the colour byte on all pins");
   comp_bcast_high_a: assert property ( // RULE_03
      output_kind_select == vg_pkg::VG_COMP_BCAST_HIGH ##0 s_group0_all |=>
      video_out_q[7:0] == {$past(bcast_nib), $past(base_nib)})
      else $error("composite mode one placed signals wrongly");
   comp_base_high_a: assert property ( // RULE_04
      output_kind_select == vg_pkg::VG_COMP_BASE_HIGH ##0 s_group0_all |=>
      video_out_q[7:0] == {$past(base_nib), $past(bcast_nib)})
      else $error("composite mode two placed signals wrongly");
   chroma_gate_a: assert property ( // RULE_07
      !broadcast_colour_enable |-> bcast_nib[3] == 1'b0)
      else $error("broadcast chroma present while disabled");
   base_chroma_gate_a: assert property ( // RULE_08
      !baseband_colour_enable |-> base_nib[3] == 1'b0)
      else $error("baseband chroma present while disabled");
   audio_source_a: assert property (1'b1 |=> audio_subcarrier_q == $past(aud_pick)) // RULE_09
      else $error("audio sub-carrier not taken from selected core");
   reserved_group_a: assert property ( // RULE_10
      output_pin_group > `VG_GROUP_LAST |=> video_drive_n_q == `VG_PINS_UNDRIVEN_N)
      else $error("reserved pin group drove pins");
   pin_mask_a: assert property ( // RULE_11
      output_kind_select != vg_pkg::VG_OFF && output_pin_group == `VG_GROUP_ZERO |=>
      video_drive_n_q[7:0] == ~$past(output_pin_mask) &&
      video_drive_n_q[31:8] == 24'hff_ffff)
      else $error("driven pins differ from the pin mask");
   pixel_spacing_a: assert property ( // RULE_12
      pixel_shift && px_clean_q |-> px_seen_q + `VG_PIXEL_ONE == pixel_period)
      else $error("pixel spacing differs from the pixel period");
   frame_spacing_a: assert property ( // RULE_13
      frame_due && fr_clean_q |-> fr_seen_q + `VG_FRAME_ONE == frame_period)
      else $error("frame spacing differs from the frame period");
   synth_only_a: assert property ( // RULE_14
      (pixel_shift || frame_due) |-> counter_a_synth_clock)
      else $error("period counter moved without a synthesiser tick");
   long_taken_a: assert property ( // RULE_15
      s_long_offer |=> s_ready_once)
      else $error("pixel long not acknowledged at frame boundary");
   ready_cause_a: assert property ( // RULE_15
      !(frame_due && pixel_long_valid) |=> !pixel_long_ready_q)
      else $error("pixel long acknowledged without a frame boundary");
   cfg_readback_a: assert property (cfg_wr |=> video_configuration_q == $past(wr_data)) // RULE_16
      else $error("configuration register read differs from last write");
   scl_readback_a: assert property (scl_wr |=> video_scale_q == $past(wr_data)) // RULE_16
      else $error("scale register read differs from last write");

   // RULE_14 - counters hold idle
   hold_no_tick_a: assert property ( // RULE_14
      !counter_a_synth_clock |=> $stable(px_cnt_q) && $stable(fr_cnt_q))
      else $error("period counters moved without a synthesiser tick");
   // RULE_12 - pixel held between
   pixel_hold_a: assert property ( // RULE_12
      !pixel_shift && !frame_due && !cfg_wr |=> $stable(pix_index))
      else $error("pixel changed between pixel boundaries");
   // RULE_11 - undriven pins low
   undriven_low_a: assert property ((video_out_q & video_drive_n_q) == `VG_PINS_OFF) // RULE_11
      else $error("undriven pin shows a high level");

   // Per-group checks of lane selection, mask and chroma placement.
   genvar h;
   generate
      for (h = 0; h < `VG_GROUP_COUNT; h = h + 1)
      begin : g_lane_chk
         idle_lane_a: assert property ( // RULE_10
            output_pin_group != 3'(h) |=>
            video_drive_n_q[h*8 +: 8] == `VG_LANE_UNDRIVEN_N &&
            video_out_q[h*8 +: 8] == `VG_LANE_OFF)
            else $error("pin group driven while not selected");
         vga_lane_a: assert property ( // RULE_02
            output_kind_select == vg_pkg::VG_VGA && output_pin_group == 3'(h) |=>
            video_out_q[h*8 +: 8] == ($past(colour) & $past(output_pin_mask)))
            else $error("VGA byte missing from the selected group");
         mask_lane_a: assert property ( // RULE_11
            output_kind_select != vg_pkg::VG_OFF && output_pin_group == 3'(h) |=>
            video_drive_n_q[h*8 +: 8] == ~$past(output_pin_mask))
            else $error("selected group drive differs from the pin mask");
         bcast_high_hue_a: assert property ( // RULE_07
            output_kind_select == vg_pkg::VG_COMP_BCAST_HIGH && output_pin_group == 3'(h) &&
            !broadcast_colour_enable |=> video_out_q[h*8 + 7] == 1'b0)
            else $error("broadcast hue driven on upper pins while chroma is off");
         bcast_low_hue_a: assert property ( // RULE_07
            output_kind_select == vg_pkg::VG_COMP_BASE_HIGH && output_pin_group == 3'(h) &&
            !broadcast_colour_enable |=> video_out_q[h*8 + 3] == 1'b0)
            else $error("broadcast hue driven on lower pins while chroma is off");
         base_low_hue_a: assert property ( // RULE_08
            output_kind_select == vg_pkg::VG_COMP_BCAST_HIGH && output_pin_group == 3'(h) &&
            !baseband_colour_enable |=> video_out_q[h*8 + 3] == 1'b0)
            else $error("baseband hue driven on lower pins while chroma is off");
         base_high_hue_a: assert property ( // RULE_08
            output_kind_select == vg_pkg::VG_COMP_BASE_HIGH && output_pin_group == 3'(h) &&
            !baseband_colour_enable |=> video_out_q[h*8 + 7] == 1'b0)
            else $error("baseband hue driven on upper pins while chroma is off");
      end
   endgenerate
endmodule

// ==== vg_feeder.sv ====
// Model of the party that hands pixel longs and palettes to the video generator.
`timescale 1ns/1ps
module vg_feeder (
   // Clock
   input wire logic clk,
   // Handshake
   input wire logic pixel_long_ready_q,
   output logic pixel_long_valid,
   output logic [31:0] pixel_long_data,
   output logic [31:0] palette_data
);
   initial
   begin
      pixel_long_valid = 1'b0;
      pixel_long_data = 32'h0;
      palette_data = 32'h0;
   end
   task automatic offer(input logic [31:0] d, input logic [31:0] p);
      @(negedge clk);
      pixel_long_valid = 1'b1;
      pixel_long_data = d;
      palette_data = p;
   endtask
   always @(posedge clk)
   begin
      if (pixel_long_ready_q && pixel_long_valid)
      begin
         pixel_long_valid <= 1'b0;
         pixel_long_data <= ~pixel_long_data;
         palette_data <= ~palette_data;
      end
   end
endmodule

// ==== tb_vg_core.sv ====
// Self-checking testbench of the per-core video generator.
`timescale 1ns/1ps
module tb_vg_core;
   logic clk = 1'b0, sys_rst = 1'b1, cfg_wr = 1'b0, scl_wr = 1'b0, tick = 1'b0;
   logic [31:0] wr_data = 32'h0, cfg_q, scl_q, out_q, drv_n_q, ldata, pal;
   logic [7:0] level = 8'h00;
   logic aud_q, valid, ready;
   int n_mismatch = 0, checks_done = 0, cycles = 0;
   always #5 clk = ~clk;
   vg_core dut (.clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .scl_wr(scl_wr),
      .wr_data(wr_data), .video_configuration_q(cfg_q), .video_scale_q(scl_q),
      .counter_a_synth_clock(tick), .core_synth_level(level), .audio_subcarrier_q(aud_q),
      .pixel_long_valid(valid), .pixel_long_data(ldata), .palette_data(pal),
      .pixel_long_ready_q(ready), .video_out_q(out_q), .video_drive_n_q(drv_n_q));
   vg_feeder feeder (.clk(clk), .pixel_long_ready_q(ready), .pixel_long_valid(valid),
      .pixel_long_data(ldata), .palette_data(pal));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      if (n_mismatch == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         wrap_up();
      end
   end
   function automatic logic [31:0] cfg_of(input logic [1:0] mode, input logic depth,
      input logic [1:0] chroma, input logic [2:0] g, input logic [7:0] m);
      return {1'b0, mode, depth, chroma, 3'h0, 11'h0, g, 1'b0, m};
   endfunction
   task automatic setup(input logic [31:0] cfg, input logic [31:0] scl);
      @(negedge clk);
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      wr_data = scl;
      scl_wr = 1'b1;
      @(negedge clk);
      scl_wr = 1'b0;
      wr_data = cfg;
      cfg_wr = 1'b1;
      @(negedge clk);
      cfg_wr = 1'b0;
      @(negedge clk);
   endtask
   // n synthesiser ticks, each followed by a wait until the pins have followed it.
   task automatic step(input int n);
      repeat (n)
      begin
         tick = 1'b1;
         @(negedge clk);
         tick = 1'b0;
         @(negedge clk);
      end
   endtask
   // A tick at a frame boundary; ready is judged in both cycles that follow it.
   task automatic step_ack(input logic exp);
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
      chk({31'h0, ready}, {31'h0, exp});
      @(negedge clk);
      chk({31'h0, ready}, 32'h0);
   endtask
   task automatic pins(input logic [2:0] g, input logic [7:0] v, input logic [7:0] m);
      logic [31:0] e_out, e_drv;
      e_out = (g < 3'h4) ? ({24'h0, v & m} << (8 * g)) : 32'h0;
      e_drv = (g < 3'h4) ? ~({24'h0, m} << (8 * g)) : 32'hffff_ffff;
      chk(out_q, e_out);
      chk(drv_n_q, e_drv);
   endtask
   task automatic t_regs();
      setup(32'h807f_f100, 32'hfff0_0000);
      chk(cfg_q, 32'h807f_f100);
      chk(scl_q, 32'hfff0_0000);
      feeder.offer(32'hffff_ffff, 32'h4433_2211);
      step(1);
      pins(3'h4, 8'h00, 8'h00);
   endtask
   task automatic t_vga();
      for (int g = 0; g < 5; g++)
      begin
         setup(cfg_of(2'h1, 1'b0, 2'h0, g[2:0], 8'hff), {12'h0, 8'h01, 12'h020});
         feeder.offer(32'h0000_0005, 32'h4433_2211);
         step_ack(1'b1);
         pins(g[2:0], 8'h22, 8'hff);
         step(1);
         pins(g[2:0], 8'h11, 8'hff);
         step(1);
         pins(g[2:0], 8'h22, 8'hff);
      end
   endtask
   task automatic t_depth();
      setup(cfg_of(2'h1, 1'b1, 2'h0, 3'h1, 8'hff) | 32'h807f_f100, {12'hfff, 8'h01, 12'h010});
      feeder.offer(32'h0000_00e4, 32'h4433_2211);
      for (int i = 0; i < 4; i++)
      begin
         step(1);
         pins(3'h1, 8'(32'h4433_2211 >> (8 * i)), 8'hff);
      end
   endtask
   task automatic t_period();
      setup(cfg_of(2'h1, 1'b0, 2'h0, 3'h0, 8'hff), {12'h0, 8'h03, 12'h060});
      feeder.offer(32'h0000_0002, 32'h4433_2211);
      step(1);
      pins(3'h0, 8'h11, 8'hff);
      step(2);
      pins(3'h0, 8'h11, 8'hff);
      repeat (20) @(negedge clk);
      pins(3'h0, 8'h11, 8'hff);
      step(1);
      pins(3'h0, 8'h22, 8'hff);
   endtask
   task automatic t_frame();
      setup(cfg_of(2'h1, 1'b0, 2'h0, 3'h3, 8'hff), {12'h0, 8'h01, 12'h004});
      feeder.offer(32'h0000_0000, 32'h4433_2211);
      step(4);
      pins(3'h3, 8'h11, 8'hff);
      feeder.offer(32'h0000_0001, 32'h0000_7766);
      step_ack(1'b1);
      pins(3'h3, 8'h77, 8'hff);
      step(3);
      pins(3'h3, 8'h66, 8'hff);
      step_ack(1'b0);
      pins(3'h3, 8'h77, 8'hff);
   endtask
   task automatic t_comp();
      logic [3:0] a, b;
      logic [7:0] m, v;
      logic [2:0] grp;
      for (int k = 0; k < 8; k++)
      begin
         m = (k == 7) ? 8'h0f : 8'hff;
         grp = {1'b0, k[0], k[1]};
         setup(cfg_of({1'b1, k[2]}, 1'b0, k[1:0], grp, m), {12'h0, 8'h01, 12'h020});
         feeder.offer(32'h0000_0000, 32'h0000_000d);
         step(1);
         b = k[1] ? 4'hd : 4'h5;
         a = k[0] ? 4'hd : 4'h5;
         v = k[2] ? {a, b} : {b, a};
         pins(grp, v, m);
      end
   endtask
   task automatic t_audio();
      for (int n = 0; n < 8; n++)
      begin
         setup({6'h0, n[2:0], 23'h0}, 32'h0);
         level = 8'h01 << n;
         repeat (2) @(negedge clk);
         chk({31'h0, aud_q}, 32'h1);
         level = ~(8'h01 << n);
         repeat (2) @(negedge clk);
         chk({31'h0, aud_q}, 32'h0);
      end
   endtask
   initial
   begin
      repeat (2) @(negedge clk);
      chk(cfg_q, 32'h0);
      chk(out_q, 32'h0);
      chk(drv_n_q, 32'hffff_ffff);
      sys_rst = 1'b0;
      t_regs();
      t_vga();
      t_depth();
      t_period();
      t_frame();
      t_comp();
      t_audio();
      wrap_up();
   end
endmodule
